// *** pda_pkg.sv ***
// shared constants and types for the program counter and data addressing block
package pda_pkg;

	// =========================================================================
	// program counter
	localparam int        PC_W        = 12;
	localparam int        PAGE_LSB    = 9;
	localparam logic [11:0] PC_RESET  = 12'hFFF;
	localparam logic [11:0] PC_ONE    = 12'h001;
	localparam int        STACK_DEPTH = 8;
	localparam int        STACK_PTR_W = 3;

	// =========================================================================
	// data memory map
	localparam int          DATA_W      = 8;
	localparam int          RF_W        = 5;
	localparam int          RAM_AW      = 9;
	localparam int          RAM_DEPTH   = 272;
	localparam logic [3:0]  REG_INDIRECT = 4'h0;
	localparam logic [3:0]  REG_PCL      = 4'h2;
	localparam logic [3:0]  REG_PTR      = 4'h4;
	localparam logic [7:0]  PTR_RESET    = 8'h00;
	localparam logic [2:0]  PAGE_RESET   = 3'h0;
	localparam logic [4:0]  RF_INDIRECT  = 5'h00;

	// =========================================================================
	// operations issued by the decoder
	typedef enum logic [2:0] {
		PDA_OP_NONE = 3'b000,
		PDA_OP_STEP = 3'b001,
		PDA_OP_JUMP = 3'b010,
		PDA_OP_CALL = 3'b011,
		PDA_OP_RET  = 3'b100,
		PDA_OP_PAGE = 3'b101,
		PDA_OP_BANK = 3'b110
	} pda_op_t;

	// source of read data
	typedef enum logic [1:0] {
		PDA_RSEL_MEM  = 2'b00,
		PDA_RSEL_PCL  = 2'b01,
		PDA_RSEL_PTR  = 2'b10,
		PDA_RSEL_ZERO = 2'b11
	} pda_rsel_t;

endpackage : pda_pkg

// *** pda_mem_if.sv ***
// carrier between the addressing logic and the data memory
`timescale 1ns/1ps
interface pda_mem_if;
	import pda_pkg::*;
	logic                  ce;
	logic                  we;
	logic [RAM_AW-1:0]     addr;
	logic [DATA_W-1:0]     wdata;
	logic [DATA_W-1:0]     rdata;

	modport ctrl (output ce, output we, output addr, output wdata, input rdata);
	modport ram  (input ce, input we, input addr, input wdata, output rdata);
endinterface : pda_mem_if

// *** pda_ram.sv ***
// banked and global data registers, registered read data
`timescale 1ns/1ps
module pda_ram #(
	parameter int DEPTH = pda_pkg::RAM_DEPTH
) (
	// clock
	input wire logic clock,
	// memory port
	pda_mem_if.ram   mem
);
	import pda_pkg::*;

	logic [DATA_W-1:0] cell_ff [DEPTH];
	logic [DATA_W-1:0] rdata_ff;

	// =========================================================================
	// storage: contents are not reset, so software must write a cell before trusting it
	always_ff @(posedge clock) begin
		if (mem.ce) begin
			if (mem.we && (int'(mem.addr) < DEPTH)) begin
				cell_ff[mem.addr] <= mem.wdata;
			end
			rdata_ff <= (int'(mem.addr) < DEPTH) ? cell_ff[mem.addr] : 8'h00;
		end
	end

	assign mem.rdata = rdata_ff;

endmodule : pda_ram

// *** pda_core.sv ***
// program counter, return stack and data memory address generation
// Notes on behaviour
// - program space is 4K words of 12 bits, fetched at a binary counter address
// - reset loads the counter with all ones, fetching the top address first
// - on a step operation the counter steps by one and wraps to zero
// - pages are 512 words; stepping crosses page boundaries freely
// - low counter byte is data register 02h; bit 8 not software accessible
// - jumps and calls take upper target bits from the page-select bits
// - page-set operation loads the page-select bits from its operand
// - eight-entry 12-bit return stack; call pushes, return pops into counter
// - return stack has no software read or write path
// - data memory: sixteen banks of sixteen bytes plus a global bank
// - register field zero is indirect, 01h-0Fh direct, 10h-1Fh semi-direct
// - indirect mode uses the full 8-bit pointer at global 04h
// - indirect pointers 01h-0Fh reach globals, higher reach banks 1 to F
// - direct mode selects a global register, ignoring the pointer
// - semi-direct address is pointer high nibble with field low nibble
// - global location zero is the indirect port, not a storage cell
// - bank-select writes only pointer bits 4 to 6
// - pointer bit 7 picks the lower or upper block of banks
`timescale 1ns/1ps
module pda_core (
	// clock and reset
	input  wire logic                            clock,
	input  wire logic                            sys_rst,
	input  wire logic                            clk_en,
	// program counter operations from the decoder
	input  wire pda_pkg::pda_op_t                op,
	input  wire logic [8:0]                      op_target,
	// data access from the decoder
	input  wire logic                            acc_valid,
	input  wire logic                            acc_write,
	input  wire logic [pda_pkg::RF_W-1:0]        register_field,
	input  wire logic [pda_pkg::DATA_W-1:0]      acc_wdata,
	// state towards the core
	output logic [pda_pkg::PC_W-1:0]             fetch_addr_ff,
	output logic [2:0]                           page_select_ff,
	output logic [pda_pkg::DATA_W-1:0]           data_pointer_ff,
	output logic [pda_pkg::DATA_W-1:0]           rd_data_ff,
	output logic                                 rd_valid_ff
);
	import pda_pkg::*;

	pda_mem_if mem ();

	// =========================================================================
	// address resolution
	wire logic        mode_indirect = (register_field == RF_INDIRECT);
	wire logic        mode_semi     = register_field[4];
	wire logic        mode_direct   = !mode_indirect && !mode_semi;
	// indirect pointer with a zero high nibble lands in the global bank
	wire logic        ind_global    = (data_pointer_ff[7:4] == 4'h0);
	wire logic        res_global    = mode_direct || (mode_indirect && ind_global);
	wire logic [7:0]  res_idx       = mode_indirect ? data_pointer_ff :
	                                  mode_semi     ? {data_pointer_ff[7:4], register_field[3:0]} :
	                                                  {4'h0, register_field[3:0]};
	wire logic [RAM_AW-1:0] res_addr = res_global ? {1'b1, 4'h0, res_idx[3:0]} : {1'b0, res_idx};

	wire logic        hit_port = res_global && (res_idx[3:0] == REG_INDIRECT);
	wire logic        hit_pcl  = res_global && (res_idx[3:0] == REG_PCL);
	wire logic        hit_ptr  = res_global && (res_idx[3:0] == REG_PTR);
	wire logic        hit_mem  = !hit_port && !hit_pcl && !hit_ptr;
	wire logic        do_write = clk_en && acc_valid && acc_write;
	wire logic        do_read  = clk_en && acc_valid && !acc_write;
	wire logic        pcl_wr   = do_write && hit_pcl;
	wire logic        ptr_wr   = do_write && hit_ptr;

	wire pda_rsel_t   rsel     = hit_pcl ? PDA_RSEL_PCL :
	                             hit_ptr ? PDA_RSEL_PTR :
	                             hit_port ? PDA_RSEL_ZERO : PDA_RSEL_MEM;

	// port through a zero pointer reads zero and drops writes
	assign mem.ce    = clk_en;
	assign mem.we    = do_write && hit_mem;
	assign mem.addr  = res_addr;
	assign mem.wdata = acc_wdata;

	pda_ram #(
		.DEPTH (RAM_DEPTH)
	) u_ram (
		.clock (clock),
		.mem   (mem)
	);

	// =========================================================================
	// program counter and return stack
	logic [PC_W-1:0]        stack_ff [STACK_DEPTH];
	logic [STACK_PTR_W-1:0] sp_ff;
	logic [PC_W-1:0]        nxt_pc;
	logic [STACK_PTR_W-1:0] nxt_sp;

	wire logic [PC_W-1:0]        pc_inc   = fetch_addr_ff + PC_ONE;
	wire logic [STACK_PTR_W-1:0] sp_prev  = sp_ff - 3'h1;
	wire logic [PC_W-1:0]        jmp_dest = {page_select_ff, op_target};
	wire logic [PC_W-1:0]        call_dest = {page_select_ff, 1'b0, op_target[7:0]};
	wire logic [PC_W-1:0]        pcl_dest = {page_select_ff, 1'b0, acc_wdata};
	wire logic                   do_push  = clk_en && !pcl_wr && (op == PDA_OP_CALL);
	wire logic                   do_pop   = clk_en && !pcl_wr && (op == PDA_OP_RET);

	// a computed jump through the low byte overrides any decoder step, jump, call or return
	always_comb begin
		nxt_pc = fetch_addr_ff;
		nxt_sp = sp_ff;
		if (pcl_wr) begin
			nxt_pc = pcl_dest;
		end else begin
			case (op)
				PDA_OP_STEP: begin
					nxt_pc = pc_inc;
				end
				PDA_OP_JUMP: begin
					nxt_pc = jmp_dest;
				end
				PDA_OP_CALL: begin
					nxt_pc = call_dest;
					nxt_sp = sp_ff + 3'h1;
				end
				PDA_OP_RET: begin
					nxt_pc = stack_ff[sp_prev];
					nxt_sp = sp_prev;
				end
				default: begin
					nxt_pc = fetch_addr_ff;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			fetch_addr_ff <= PC_RESET;
			sp_ff         <= '0;
		end else if (clk_en) begin
			fetch_addr_ff <= nxt_pc;
			sp_ff         <= nxt_sp;
		end
	end

	// stack is a ring: a ninth call overwrites the oldest return address
	genvar gi;
	generate
		for (gi = 0; gi < STACK_DEPTH; gi++) begin : g_stack
			always_ff @(posedge clock) begin
				if (sys_rst) begin
					stack_ff[gi] <= PC_RESET;
				end else if (do_push && (sp_ff == STACK_PTR_W'(gi))) begin
					stack_ff[gi] <= pc_inc;
				end
			end
		end
	endgenerate

	// =========================================================================
	// page select and data pointer
	logic [7:0] nxt_ptr;
	assign nxt_ptr = ptr_wr ? acc_wdata :
	                 (op == PDA_OP_BANK) ? {data_pointer_ff[7], op_target[6:4], data_pointer_ff[3:0]} :
	                 data_pointer_ff;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			page_select_ff  <= PAGE_RESET;
			data_pointer_ff <= PTR_RESET;
		end else if (clk_en) begin
			if (op == PDA_OP_PAGE) begin
				page_select_ff <= op_target[2:0];
			end
			data_pointer_ff <= nxt_ptr;
		end
	end

	// =========================================================================
	// read pipeline: the memory answers one edge after the request, data out one later
	logic       rd_pend_ff;
	pda_rsel_t  rd_sel_ff;
	logic [7:0] rd_spec_ff;
	logic [7:0] nxt_rd_data;

	assign nxt_rd_data = (rd_sel_ff == PDA_RSEL_MEM)  ? mem.rdata :
	                     (rd_sel_ff == PDA_RSEL_ZERO) ? 8'h00 : rd_spec_ff;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rd_pend_ff  <= 1'b0;
			rd_sel_ff   <= PDA_RSEL_ZERO;
			rd_spec_ff  <= 8'h00;
			rd_data_ff  <= 8'h00;
			rd_valid_ff <= 1'b0;
		end else if (clk_en) begin
			rd_pend_ff  <= do_read;
			rd_sel_ff   <= rsel;
			rd_spec_ff  <= hit_pcl ? fetch_addr_ff[7:0] : data_pointer_ff;
			rd_valid_ff <= rd_pend_ff;
			if (rd_pend_ff) begin
				rd_data_ff <= nxt_rd_data;
			end
		end
	end

	// =========================================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	reset_pc_a: assert property ($past(sys_rst) |-> fetch_addr_ff == 12'hFFF)
		else $error("counter not at top address after reset");
	pc_step_a: assert property (clk_en && op == PDA_OP_STEP && !pcl_wr
		|=> fetch_addr_ff == 12'($past(fetch_addr_ff) + 12'h001))
		else $error("counter did not step by one");
	jump_page_a: assert property (clk_en && op == PDA_OP_JUMP && !pcl_wr
		|=> fetch_addr_ff == {$past(page_select_ff), $past(op_target)})
		else $error("jump target not built from page bits");
	page_set_a: assert property (clk_en && op == PDA_OP_PAGE
		|=> page_select_ff == $past(op_target[2:0]))
		else $error("page bits not loaded");
	call_ret_a: assert property (clk_en && op == PDA_OP_CALL && !pcl_wr ##1
		clk_en && op == PDA_OP_RET && !pcl_wr |=> fetch_addr_ff == 12'($past(fetch_addr_ff, 2) + 12'h001))
		else $error("return did not restore call address");
	bank_set_a: assert property (clk_en && op == PDA_OP_BANK && !ptr_wr
		|=> data_pointer_ff == {$past(data_pointer_ff[7]), $past(op_target[6:4]), $past(data_pointer_ff[3:0])})
		else $error("bank select touched other pointer bits");
	direct_map_a: assert property (acc_valid && mode_direct
		|-> mem.addr == {1'b1, 4'h0, register_field[3:0]})
		else $error("direct access left the global bank");
	semi_map_a: assert property (acc_valid && mode_semi
		|-> mem.addr == {1'b0, data_pointer_ff[7:4], register_field[3:0]})
		else $error("semi-direct address wrong");
	indirect_map_a: assert property (acc_valid && mode_indirect && data_pointer_ff[7:4] != 4'h0
		|-> mem.addr == {1'b0, data_pointer_ff})
		else $error("indirect access missed the banks");
	pcl_write_a: assert property (pcl_wr
		|=> fetch_addr_ff == {$past(page_select_ff), 1'b0, $past(acc_wdata)})
		else $error("computed jump target wrong");
	read_lat_a: assert property (do_read |=> rd_pend_ff)
		else $error("read request lost");

	// the read pipeline moves only on enabled edges, so valid follows the pending flag
	rd_pulse_a: assert property (clk_en |=> rd_valid_ff == $past(rd_pend_ff))
		else $error("read valid not one cycle after pending");

	pcl_read_a: assert property (do_read && mode_direct && register_field[3:0] == REG_PCL ##1 clk_en
		|=> rd_data_ff == $past(fetch_addr_ff[7:0], 2))
		else $error("counter low byte read wrong");

	ptr_read_a: assert property (do_read && mode_direct && register_field[3:0] == REG_PTR ##1 clk_en
		|=> rd_data_ff == $past(data_pointer_ff, 2))
		else $error("pointer read wrong");

	ptr_write_a: assert property (ptr_wr |=> data_pointer_ff == $past(acc_wdata))
		else $error("pointer write lost");

	// the port through a zero pointer holds nothing: writes vanish, reads give zero
	port_drop_a: assert property (do_write && mode_indirect && data_pointer_ff == 8'h00 |-> !mem.we)
		else $error("write through a zero pointer reached memory");

	port_read_a: assert property (do_read && mode_indirect && data_pointer_ff == 8'h00 ##1 clk_en
		|=> rd_data_ff == 8'h00)
		else $error("read through a zero pointer not zero");

	ind_global_a: assert property (acc_valid && mode_indirect && data_pointer_ff[7:4] == 4'h0
		|-> mem.addr == {1'b1, 4'h0, data_pointer_ff[3:0]})
		else $error("indirect access missed the global bank");

	// state may move only through its own operations
	freeze_hold_a: assert property (!clk_en |=> $stable(fetch_addr_ff) && $stable(page_select_ff)
		&& $stable(data_pointer_ff) && $stable(rd_valid_ff) && $stable(rd_data_ff))
		else $error("state moved with the enable low");

	counter_hold_a: assert property (clk_en && !pcl_wr
		&& (op == PDA_OP_NONE || op == PDA_OP_PAGE || op == PDA_OP_BANK) |=> $stable(fetch_addr_ff))
		else $error("counter moved without a branch or step");

	pc_wrap_a: assert property (clk_en && !pcl_wr && op == PDA_OP_STEP && fetch_addr_ff == PC_RESET
		|=> fetch_addr_ff == 12'h000)
		else $error("counter did not wrap to zero");

	page_hold_a: assert property (!(clk_en && op == PDA_OP_PAGE) |=> $stable(page_select_ff))
		else $error("page bits moved without a page operation");

	ptr_hold_a: assert property (!ptr_wr && !(clk_en && op == PDA_OP_BANK) |=> $stable(data_pointer_ff))
		else $error("pointer moved without a write or bank select");

	// the stack pointer moves only on calls and returns, so software cannot reach the stack
	stack_hold_a: assert property (!do_push && !do_pop |=> $stable(sp_ff))
		else $error("stack pointer moved without a call or return");

	call_push_a: assert property (do_push |=> stack_ff[sp_prev] == 12'($past(fetch_addr_ff) + 12'h001))
		else $error("call pushed the wrong return address");

	call_target_a: assert property (do_push
		|=> fetch_addr_ff == {$past(page_select_ff), 1'b0, $past(op_target[7:0])})
		else $error("call target not built from page bits");

	ret_pop_a: assert property (do_pop |=> sp_ff == 3'($past(sp_ff) - 3'h1))
		else $error("return did not pop the stack");

	call_c: cover property (clk_en && op == PDA_OP_CALL);
	ret_c: cover property (clk_en && op == PDA_OP_RET);
	ind_write_c: cover property (do_write && mode_indirect && !ind_global);
	semi_read_c: cover property (do_read && mode_semi ##2 rd_valid_ff);
	step_freeze_c: cover property (!clk_en && op == PDA_OP_STEP);

endmodule : pda_core

// *** pda_dec_model.sv ***
// decoder-side model issuing counter operations and data accesses
`timescale 1ns/1ps
module pda_dec_model (
	// clock
	input  wire logic                       clock,
	// requests towards the block
	output logic                            clk_en,
	output pda_pkg::pda_op_t                op,
	output logic [8:0]                      op_target,
	output logic                            acc_valid,
	output logic                            acc_write,
	output logic [pda_pkg::RF_W-1:0]        register_field,
	output logic [pda_pkg::DATA_W-1:0]      acc_wdata
);
	import pda_pkg::*;

	initial begin
		clk_en = 1'b1;
		op = PDA_OP_NONE;
		op_target = 9'h000;
		acc_valid = 1'b0;
		acc_write = 1'b0;
		register_field = 5'h00;
		acc_wdata = 8'h00;
	end

	// =========================================================================
	// one request per call, held for exactly the edge that takes it
	task run_op(input pda_op_t o, input logic [8:0] t);
		@(posedge clock);
		op <= o;
		op_target <= t;
		@(posedge clock);
		op <= PDA_OP_NONE;
		#1;
	endtask : run_op

	task access(input logic w, input logic [4:0] f, input logic [7:0] d);
		@(posedge clock);
		acc_valid <= 1'b1;
		acc_write <= w;
		register_field <= f;
		acc_wdata <= d;
		@(posedge clock);
		acc_valid <= 1'b0;
		// data line no longer meaningful, so do not leave the old value
		acc_wdata <= ~d;
		#1;
	endtask : access

	// two operations on consecutive edges, the second replacing the first
	task run_pair(input pda_op_t o1, input logic [8:0] t1, input pda_op_t o2, input logic [8:0] t2);
		@(posedge clock);
		op <= o1;
		op_target <= t1;
		@(posedge clock);
		op <= o2;
		op_target <= t2;
		@(posedge clock);
		op <= PDA_OP_NONE;
		#1;
	endtask : run_pair

	task set_enable(input logic en);
		@(posedge clock);
		clk_en <= en;
		#1;
	endtask : set_enable
endmodule : pda_dec_model

// *** pc_and_data_addressing_tb.sv ***
// self-checking testbench for the program counter and data addressing block
`timescale 1ns/1ps
module pc_and_data_addressing_tb;
	import pda_pkg::*;

	logic              clock;
	logic              sys_rst;
	wire logic         clk_en;
	pda_op_t           op;
	wire logic [8:0]   op_target;
	wire logic         acc_valid;
	wire logic         acc_write;
	wire logic [4:0]   register_field;
	wire logic [7:0]   acc_wdata;
	logic [11:0]       fetch_addr_ff;
	logic [2:0]        page_select_ff;
	logic [7:0]        data_pointer_ff;
	logic [7:0]        rd_data_ff;
	logic              rd_valid_ff;
	int                errors;
	int                num_checks;

	pda_dec_model dec_u (.clock(clock), .clk_en(clk_en), .op(op), .op_target(op_target),
		.acc_valid(acc_valid), .acc_write(acc_write), .register_field(register_field), .acc_wdata(acc_wdata));

	pda_core dut_u (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .op(op), .op_target(op_target),
		.acc_valid(acc_valid), .acc_write(acc_write), .register_field(register_field),
		.acc_wdata(acc_wdata), .fetch_addr_ff(fetch_addr_ff), .page_select_ff(page_select_ff),
		.data_pointer_ff(data_pointer_ff), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff));

	// =========================================================================
	// shared helpers
	task chk(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [4:0] f, input logic [7:0] d);
		dec_u.access(1'b1, f, d);
	endtask : wr

	// read answer comes one enabled edge after the request is taken
	task rd(input logic [4:0] f, input logic [7:0] exp);
		dec_u.access(1'b0, f, 8'h00);
		repeat (4) begin
			@(posedge clock);
			#1;
			if (rd_valid_ff === 1'b1) break;
		end
		chk({11'h000, rd_valid_ff}, 12'h001);
		chk({4'h0, rd_data_ff}, {4'h0, exp});
	endtask : rd

	task wrap_up;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	// =========================================================================
	// scenarios
	task t_reset;
		#1;
		chk(fetch_addr_ff, 12'hFFF);
		chk({9'h000, page_select_ff}, 12'h000);
		dec_u.run_op(PDA_OP_STEP, 9'h000);
		chk(fetch_addr_ff, 12'h000);
		$display("test reset done");
	endtask : t_reset

	task t_pages;
		dec_u.run_op(PDA_OP_JUMP, 9'h1FF);
		chk(fetch_addr_ff, 12'h1FF);
		dec_u.run_op(PDA_OP_STEP, 9'h000);
		chk(fetch_addr_ff, 12'h200);
		dec_u.run_op(PDA_OP_PAGE, 9'h005);
		chk({9'h000, page_select_ff}, 12'h005);
		chk(fetch_addr_ff, 12'h200);
		dec_u.run_op(PDA_OP_JUMP, 9'h0A3);
		chk(fetch_addr_ff, 12'hAA3);
		rd(5'h02, 8'hA3);
		$display("test pages done");
	endtask : t_pages

	// back-to-back calls nest two deep before unwinding
	task t_stack;
		dec_u.run_op(PDA_OP_CALL, 9'h112);
		chk(fetch_addr_ff, 12'hA12);
		dec_u.run_op(PDA_OP_CALL, 9'h034);
		chk(fetch_addr_ff, 12'hA34);
		dec_u.run_op(PDA_OP_RET, 9'h000);
		chk(fetch_addr_ff, 12'hA13);
		dec_u.run_op(PDA_OP_RET, 9'h000);
		chk(fetch_addr_ff, 12'hAA4);
		wr(5'h02, 8'h77);
		chk(fetch_addr_ff, 12'hA77);
		dec_u.run_pair(PDA_OP_CALL, 9'h056, PDA_OP_RET, 9'h000);
		chk(fetch_addr_ff, 12'hA78);
		$display("test stack done");
	endtask : t_stack

	task t_data;
		wr(5'h04, 8'hF5);
		chk({4'h0, data_pointer_ff}, 12'h0F5);
		wr(5'h00, 8'h01);
		wr(5'h04, 8'hF0);
		rd(5'h15, 8'h01);
		wr(5'h0F, 8'h5A);
		rd(5'h0F, 8'h5A);
		wr(5'h04, 8'h0F);
		rd(5'h00, 8'h5A);
		wr(5'h00, 8'hC3);
		rd(5'h0F, 8'hC3);
		wr(5'h04, 8'h00);
		rd(5'h00, 8'h00);
		wr(5'h10, 8'h66);
		wr(5'h04, 8'h10);
		wr(5'h00, 8'h88);
		wr(5'h04, 8'h05);
		rd(5'h10, 8'h66);
		wr(5'h04, 8'h15);
		rd(5'h10, 8'h88);
		rd(5'h04, 8'h15);
		$display("test data done");
	endtask : t_data

	task t_bank;
		wr(5'h04, 8'h80);
		dec_u.run_op(PDA_OP_BANK, 9'h020);
		chk({4'h0, data_pointer_ff}, 12'h0A0);
		wr(5'h04, 8'h0F);
		dec_u.run_op(PDA_OP_BANK, 9'h1F0);
		chk({4'h0, data_pointer_ff}, 12'h07F);
		$display("test bank done");
	endtask : t_bank

	// with the enable low nothing moves, then stepping resumes
	task t_freeze;
		dec_u.set_enable(1'b0);
		dec_u.run_op(PDA_OP_STEP, 9'h000);
		chk(fetch_addr_ff, 12'hA78);
		wr(5'h04, 8'h3C);
		chk({4'h0, data_pointer_ff}, 12'h07F);
		dec_u.set_enable(1'b1);
		dec_u.run_op(PDA_OP_STEP, 9'h000);
		chk(fetch_addr_ff, 12'hA79);
		$display("test freeze done");
	endtask : t_freeze

	// =========================================================================
	// clock, reset, sequence and watchdog
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	initial begin
		errors = 0;
		num_checks = 0;
		sys_rst = 1'b1;
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset;
		t_pages;
		t_stack;
		t_data;
		t_bank;
		t_freeze;
		wrap_up;
	end

	// whole sequence needs just under a hundred cycles
	initial begin
		repeat (3000) @(posedge clock);
		errors++;
		wrap_up;
	end
endmodule : pc_and_data_addressing_tb
